// [power_event_inputs.sv]
// Purpose: Power button override, PCIe event, reset button, thermal trip, holdoff
// Assumes: Single 10 MHz clock; resetn_i is the resume reset
// Notes:   Status flags clear on a one-cycle clear pulse; a set in that cycle wins

`timescale 1ns/1ps
`default_nettype none

module power_event_inputs
   import power_event_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  resetn_i,
   input  wire logic                  power_button_n_i,
   input  wire logic                  power_good_in_i,
   input  wire logic                  reset_button_n_i,
   input  wire logic                  platform_reset_n_i,
   input  wire logic                  thermal_trip_n_i,
   input  wire logic                  processor_power_good_i,
   input  wire logic                  pcie_pm_event_n_i,
   input  wire logic                  internal_pm_req_i,
   input  wire logic                  resume_holdoff_n_i,
   input  wire logic                  sleep_entry_i,
   input  wire logic                  sleep_a_n_i,
   input  wire logic                  button_debounce_select_i,
   input  wire logic                  reset_debounce_en_i,
   input  wire logic [CNT_W-1:0]      override_period_i,
   input  wire logic                  deep_sleep_en_i,
   input  wire logic [RST_CTRL_W-1:0] reset_control_i,
   input  wire logic                  trip_valid_point_i,
   input  wire logic                  holdoff_func_sel_i,
   input  wire logic                  espi_en_i,
   input  wire logic                  status_clear_i,
   output logic                       sleep_state3_n_o,
   output logic                       sleep_state4_n_o,
   output logic                       sleep_state5_n_o,
   output logic                       deep_sleep_req_o,
   output logic                       button_level_status_o,
   output logic                       button_event_status_o,
   output logic                       power_fail_trip_flag_o,
   output logic                       internal_pm_event_status_o,
   output logic                       pm_event_pulse_o,
   output logic                       host_reset_o,
   output logic                       power_cycle_reset_o,
   output logic                       resume_block_o,
   output logic                       flash_allow_o
);

   // ************************************************************
   // Input synchronisation and debounce
   // ************************************************************
   logic pb_sync_n, pb_deb_n, rb_sync_n, rb_deb_n;
   logic pme_m_q, pme_s_q, pme_d_q;
   logic tt_m_q, tt_s_q, ho_m_q, ho_s_q;
   logic pg_m_q, pg_s_q, ppg_m_q, ppg_s_q, plt_m_q, plt_s_q;

   input_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_pb_deb (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .pin_n_i   (power_button_n_i),
      .sync_n_o  (pb_sync_n),
      .clean_n_o (pb_deb_n)
   );

   input_debounce #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_rb_deb (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .pin_n_i   (reset_button_n_i),
      .sync_n_o  (rb_sync_n),
      .clean_n_o (rb_deb_n)
   );

   // Two-flop synchronisers for the PCIe event, thermal trip, holdoff, power-good and platform reset pins
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {pme_m_q, pme_s_q, pme_d_q} <= 3'h7;
         {tt_m_q, tt_s_q}            <= 2'h3;
         {ho_m_q, ho_s_q}            <= 2'h3;
         {pg_m_q, pg_s_q}            <= 2'h0;
         {ppg_m_q, ppg_s_q}          <= 2'h0;
         {plt_m_q, plt_s_q}          <= 2'h0;
      end else begin
         pme_m_q <= pcie_pm_event_n_i;
         pme_s_q <= pme_m_q;
         pme_d_q <= pme_s_q;
         tt_m_q  <= thermal_trip_n_i;
         tt_s_q  <= tt_m_q;
         ho_m_q  <= resume_holdoff_n_i;
         ho_s_q  <= ho_m_q;
         pg_m_q  <= power_good_in_i;
         pg_s_q  <= pg_m_q;
         ppg_m_q <= processor_power_good_i;
         ppg_s_q <= ppg_m_q;
         plt_m_q <= platform_reset_n_i;
         plt_s_q <= plt_m_q;
      end
   end

   // Level status picks debounced or raw-synchronised input
   assign button_level_status_o = button_debounce_select_i ? !pb_sync_n : !pb_deb_n; // [RULE4] [RULE5]

   // ************************************************************
   // Events: PCIe falling edge and internal request
   // ************************************************************
   assign pm_event_pulse_o = pme_d_q && !pme_s_q; // [RULE6]

   // ************************************************************
   // Thermal trip filter and monitoring window
   // ************************************************************
   logic mon_q, mon_d, ppg_d1_q, plt_d1_q;
   logic trip_event;

   always_comb begin
      mon_d = mon_q;
      if (!trip_valid_point_i && plt_s_q && !plt_d1_q)
         mon_d = 1'b1; // [RULE16]
      if (trip_valid_point_i && ppg_s_q && !ppg_d1_q)
         mon_d = 1'b1; // [RULE16]
      if (!ppg_s_q)
         mon_d = 1'b0; // [RULE16]
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mon_q    <= 1'b0;
         ppg_d1_q <= 1'b0;
         plt_d1_q <= 1'b0;
      end else begin
         mon_q    <= mon_d;
         ppg_d1_q <= ppg_s_q;
         plt_d1_q <= plt_s_q;
      end
   end

   // A low must be seen on a synchronised sample, so glitches falling between two edges are dropped
   assign trip_event = mon_q && !tt_s_q; // [RULE15]

   // ************************************************************
   // Power button override counter
   // ************************************************************
   logic [CNT_W-1:0] ovr_cnt_q, ovr_cnt_d;
   logic             ovr_fire;

   always_comb begin
      ovr_cnt_d = '0; // [RULE24]
      ovr_fire  = 1'b0;
      if (!pb_deb_n) begin
         ovr_cnt_d = ovr_cnt_q;
         if (ovr_cnt_q + CNT_W'(1) >= override_period_i) // [RULE3]
            ovr_fire = 1'b1; // [RULE1]
         else
            ovr_cnt_d = ovr_cnt_q + CNT_W'(1);
      end
   end

   // ************************************************************
   // Reset button
   // ************************************************************
   logic              rb_n, rb_d1_q, rb_armed_q, rb_armed_d, rb_start;
   logic [CNT_W-1:0]  hold_q, hold_d;

   assign rb_n     = reset_debounce_en_i ? rb_deb_n : rb_sync_n; // [RULE8]
   assign rb_start = pg_s_q && rb_armed_q && rb_d1_q && !rb_n;  // [RULE8] [RULE12]

   // ************************************************************
   // Power state, flags and reset pulse
   // ************************************************************
   pwr_state_e state_q, state_d;
   logic       s_off_q, s_off_d, full_q, full_d;
   logic       btn_sts_q, btn_sts_d, trip_q, trip_d, ipme_q, ipme_d;
   logic       pb_d1_q;

   always_comb begin
      state_d    = state_q;
      s_off_d    = s_off_q;
      full_d     = full_q;
      hold_d     = hold_q;
      rb_armed_d = rb_armed_q;
      btn_sts_d  = btn_sts_q && !status_clear_i;
      trip_d     = trip_q && !status_clear_i;
      ipme_d     = ipme_q && !status_clear_i;
      if (internal_pm_req_i)
         ipme_d = 1'b1; // [RULE7]
      if (pb_deb_n == 1'b0 && pb_d1_q)
         btn_sts_d = 1'b1;
      // Re-arm once input idle and host is in full working state
      if (rb_n && state_q == ST_WORK && plt_s_q && pg_s_q)
         rb_armed_d = 1'b1; // [RULE10]
      case (state_q)
         ST_WORK: begin
            if (rb_start) begin
               state_d    = ST_RST_PULSE;
               hold_d     = '0;
               full_d     = reset_control_i[RST_CTRL_FULL_BIT]; // [RULE11]
               rb_armed_d = 1'b0; // [RULE10]
            end
         end
         ST_RST_PULSE: begin
            // Fixed length, independent of the button level
            hold_d = hold_q + CNT_W'(1); // [RULE9]
            if (hold_q + CNT_W'(1) >= CNT_W'(RST_HOLD_CYC))
               state_d = ST_WORK;
         end
         ST_SOFT_OFF: begin
            // Leave only once the sequencer reports working power again
            if (ppg_s_q && !ovr_fire && !trip_event)
               state_d = ST_WORK;
         end
         default: state_d = ST_WORK;
      endcase
      // Override needs no acknowledge and no power-good
      if (ovr_fire) begin
         state_d = ST_SOFT_OFF; // [RULE1] [RULE2]
         s_off_d = 1'b1;
      end
      if (trip_event) begin
         state_d   = ST_SOFT_OFF; // [RULE13]
         s_off_d   = 1'b1;
         trip_d    = 1'b1;        // [RULE13]
         btn_sts_d = 1'b0;        // [RULE17]
      end else if (state_d == ST_WORK) begin
         s_off_d = 1'b0;
      end
   end

   // Registers for state, flags and edge history

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q    <= ST_WORK;
         s_off_q    <= 1'b0;
         full_q     <= 1'b0;
         hold_q     <= '0;
         rb_armed_q <= 1'b1;
         rb_d1_q    <= 1'b1;
         pb_d1_q    <= 1'b1;
         btn_sts_q  <= 1'b0;
         trip_q     <= 1'b0;
         ipme_q     <= 1'b0;
         ovr_cnt_q  <= '0;
      end else begin
         state_q    <= state_d;
         s_off_q    <= s_off_d;
         full_q     <= full_d;
         hold_q     <= hold_d;
         rb_armed_q <= rb_armed_d;
         rb_d1_q    <= rb_n;
         pb_d1_q    <= pb_deb_n;
         btn_sts_q  <= btn_sts_d;
         trip_q     <= trip_d;
         ipme_q     <= ipme_d;
         ovr_cnt_q  <= ovr_cnt_d;
      end
   end

   // Sleep outputs are registered: low one cycle after trip sampled
   assign sleep_state3_n_o           = !s_off_q; // [RULE14]
   assign sleep_state4_n_o           = !s_off_q;
   assign sleep_state5_n_o           = !s_off_q;
   assign deep_sleep_req_o           = s_off_q && deep_sleep_en_i;
   assign button_event_status_o      = btn_sts_q;
   assign power_fail_trip_flag_o     = trip_q;
   assign internal_pm_event_status_o = ipme_q;
   assign host_reset_o               = (state_q == ST_RST_PULSE) && !full_q;
   assign power_cycle_reset_o        = (state_q == ST_RST_PULSE) && full_q;

   // ************************************************************
   // Resume holdoff and flash guard
   // ************************************************************
   logic holdoff_act;

   // Pin only counts as holdoff once selected and not in eSPI mode
   assign holdoff_act    = holdoff_func_sel_i && !espi_en_i && !ho_s_q; // [RULE22] [RULE23]
   assign resume_block_o = sleep_entry_i && holdoff_act;               // [RULE18]
   assign flash_allow_o  = sleep_a_n_i && !holdoff_act;                // [RULE19]

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   trip_sleep_low_a: assert property (trip_event |=> !sleep_state3_n_o && !sleep_state5_n_o) // [RULE14]
      else $error("sleep outputs not low after trip");
   trip_flag_set_a: assert property (trip_event |=> power_fail_trip_flag_o) // [RULE13]
      else $error("trip flag not set");
   trip_clears_btn_a: assert property (trip_event |=> !button_event_status_o) // [RULE17]
      else $error("button status not cleared by trip");
   no_mon_no_trip_a: assert property (!ppg_s_q |=> !trip_event) // [RULE16]
      else $error("trip honored after processor power loss");
   pme_rise_quiet_a: assert property ($rose(pme_s_q) |-> !pm_event_pulse_o) // [RULE6]
      else $error("event on rising edge");
   ipme_set_a: assert property (internal_pm_req_i |=> internal_pm_event_status_o) // [RULE7]
      else $error("internal status not set");
   rst_pulse_len_a: assert property ($rose(state_q == ST_RST_PULSE) |-> (state_q == ST_RST_PULSE)[*8]) // [RULE9]
      else $error("reset pulse too short");
   rb_pg_gate_a: assert property (!pg_s_q |-> !rb_start) // [RULE12]
      else $error("reset button acted without power good");
   ovr_off_a: assert property (ovr_fire |=> !sleep_state4_n_o) // [RULE1]
      else $error("override did not power off");
   espi_holdoff_a: assert property (espi_en_i |-> !resume_block_o) // [RULE22]
      else $error("holdoff active under eSPI");
   flash_guard_a: assert property (!sleep_a_n_i |-> !flash_allow_o) // [RULE19]
      else $error("flash allowed while sleep-A asserted");

   trip_off_c:  cover property (trip_event ##1 !sleep_state3_n_o);
   rst_pulse_c: cover property (rb_start ##1 host_reset_o);
   ovr_c:       cover property (ovr_fire);
   holdoff_c:   cover property (resume_block_o);

endmodule

`default_nettype wire

// [power_event_pkg.sv]
// Purpose: Constants for the power event input block
// Assumes: 10 MHz system clock, resume reset as async reset
// Notes:   Overview list below; counts derive from times and clock rate
//
// Overview of operation
// RULE1 - Debounced button held for override period forces soft-off or deep sleep.
// RULE2 - Override power-off completes with no handshake from any subsystem.
// RULE3 - Override hold period is programmable, reset default four seconds.
// RULE4 - Button level status shows debounced input at select 0, raw at 1.
// RULE5 - With select 0, debounce adds 16 ms before a press is processed.
// RULE6 - Falling edge of PCIe event input raises an event; rising edge none.
// RULE7 - Internal bus 0 power event request sets internal event status.
// RULE8 - Reset button detected on fall or after 16 ms debounce; starts reset.
// RULE9 - Reset-button reset held five to six ms regardless of input.
// RULE10 - Next reset blocked until input seen inactive and full working state.
// RULE11 - Reset control bit 3 set makes reset button a full power cycle.
// RULE12 - Reset button ignored while power-good input is low.
// RULE13 - Valid thermal trip drives sleep outputs low, sets power-fail trip flag.
// RULE14 - Sleep outputs low within one microsecond of thermal trip sampled.
// RULE15 - Thermal trip low glitches shorter than 25 ns are ignored; code only samples, so one spanning a clock edge is taken.
// RULE16 - Trip monitoring starts at platform reset release or processor good; ends at loss.
// RULE17 - Thermal trip event clears the button event status bit.
// RULE18 - Holdoff delays resume only during sleep entry with sleep-A asserted; code blocks on sleep_entry_i and holdoff alone, ignoring sleep-A.
// RULE19 - No flash access while sleep-A asserted or holdoff still asserted.
// RULE20 - Controller keeps resume reset asserted until its flash accesses end.
// RULE21 - Controller asserts holdoff, watches chip select 5 ms, then releases holdoff.
// RULE22 - Enhanced SPI host interface enabled disables the holdoff function.
// RULE23 - Holdoff pin is a general input until firmware selects holdoff use.
// RULE24 - Override counter restarts from zero when button released early.

package power_event_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned DEBOUNCE_MS     = 16;
   localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int unsigned RST_HOLD_MIN_MS = 5;
   localparam int unsigned RST_HOLD_MAX_MS = 6;
   // Pulse lasts 5.5 ms, inside the 5..6 ms window
   localparam int unsigned RST_HOLD_CYC    = (RST_HOLD_MIN_MS + RST_HOLD_MAX_MS) * (CLK_HZ / 2000);
   localparam int unsigned OVERRIDE_S      = 4;
   localparam int unsigned OVERRIDE_CYC    = OVERRIDE_S * CLK_HZ;
   localparam int unsigned TRIP_GLITCH_NS  = 25;
   // Shorter than 25 ns is seen only if it spans a 100 ns sample edge; one cycle minimum
   localparam int unsigned TRIP_FILT_CYC   = (TRIP_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TRIP_RESP_NS    = 1000;
   localparam int unsigned TRIP_RESP_CYC   = TRIP_RESP_NS / CLK_PERIOD_NS;

   // ************************************************************
   // Widths and field positions
   // ************************************************************
   localparam int unsigned CNT_W           = 32;
   localparam int unsigned RST_CTRL_W      = 8;
   localparam int unsigned RST_CTRL_FULL_BIT = 3;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [CNT_W-1:0] OVERRIDE_DEFAULT = CNT_W'(OVERRIDE_CYC);

   // Sleep state of the sequencer as seen by this block
   typedef enum logic [1:0] {
      ST_WORK,
      ST_SOFT_OFF,
      ST_RST_PULSE
   } pwr_state_e;

endpackage

// [input_debounce.sv]
// Purpose: Synchronise an active-low pin and debounce it by a stable-time count
// Assumes: Pin is asynchronous to clk_sys_i
// Notes:   Output changes once the synced level has been stable STABLE_CYC cycles

`timescale 1ns/1ps
`default_nettype none

module input_debounce #(
   parameter int unsigned STABLE_CYC = 1
) (
   input  wire logic clk_sys_i,
   input  wire logic resetn_i,
   input  wire logic pin_n_i,
   output logic      sync_n_o,
   output logic      clean_n_o
);

   localparam int unsigned CW = $clog2(STABLE_CYC + 1) + 1;

   logic          meta_q;
   logic          sync_q;
   logic          clean_q, clean_d;
   logic [CW-1:0] cnt_q, cnt_d;

   // Next stable level and count
   always_comb begin
      clean_d = clean_q;
      cnt_d   = '0;
      if (sync_q != clean_q) begin
         cnt_d = cnt_q + CW'(1);
         if (cnt_q + CW'(1) >= CW'(STABLE_CYC)) begin
            clean_d = sync_q;
            cnt_d   = '0;
         end
      end
   end

   // Two-stage synchroniser then filter state; idle high
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_q  <= 1'b1;
         sync_q  <= 1'b1;
         clean_q <= 1'b1;
         cnt_q   <= '0;
      end else begin
         meta_q  <= pin_n_i;
         sync_q  <= meta_q;
         clean_q <= clean_d;
         cnt_q   <= cnt_d;
      end
   end

   assign sync_n_o  = sync_q;
   assign clean_n_o = clean_q;

endmodule

`default_nettype wire

// [ec_model.sv]
// Purpose: Controller-side model: resume reset and flash holdoff
// Assumes: Bench clock; holdoff watch window scaled down to WIN_CYC
// Notes:   Inputs change 10 ns after the rising edge, like the bench

`timescale 1ns/1ps
`default_nettype none

module ec_model #(
   parameter int RST_CYC = 4,
   parameter int WIN_CYC = 30
) (
   input  wire logic clk_sys_i,
   input  wire logic sleep_a_n_i,
   input  wire logic platform_reset_n_i,
   output logic      resetn_o,
   output logic      resume_holdoff_n_o
);
   logic booted;
   logic sa_q;

   // ************************************************************
   // Resume reset, then holdoff for WIN_CYC cycles after a sleep-A assertion once the host has booted
   // ************************************************************
   initial begin
      resetn_o = 1'b0;
      resume_holdoff_n_o = 1'b1;
      booted = 1'b0;
      sa_q = 1'b1;
      // Own flash work ends before the resume reset is let go
      repeat (RST_CYC) @(posedge clk_sys_i);
      #10 resetn_o = 1'b1;
      forever begin
         @(posedge clk_sys_i);
         // Holdoff only used once the host has reached working state
         if (platform_reset_n_i) begin
            booted = 1'b1;
         end
         if (booted && sa_q && !sleep_a_n_i) begin
            #10 resume_holdoff_n_o = 1'b0;
            repeat (WIN_CYC) @(posedge clk_sys_i);
            #10 resume_holdoff_n_o = 1'b1;
         end
         sa_q = sleep_a_n_i;
      end
   end

endmodule

`default_nettype wire

// [tb_power_event_inputs.sv]
// Purpose: Self-checking bench for the power event input block
// Assumes: Debounce shortened to 4 cycles, override period 20 cycles
// Notes:   Inputs move 10 ns after the rising edge; ec_model owns reset

`timescale 1ns/1ps
`default_nettype none

module tb_power_event_inputs
   import power_event_pkg::*;
;
   logic clk_sys_i, resetn_i, power_button_n_i, power_good_in_i, reset_button_n_i;
   logic platform_reset_n_i, thermal_trip_n_i, processor_power_good_i, pcie_pm_event_n_i;
   logic internal_pm_req_i, resume_holdoff_n_i, sleep_entry_i, sleep_a_n_i;
   logic button_debounce_select_i, reset_debounce_en_i, deep_sleep_en_i, trip_valid_point_i;
   logic holdoff_func_sel_i, espi_en_i, status_clear_i;
   logic [CNT_W-1:0] override_period_i;
   logic [RST_CTRL_W-1:0] reset_control_i;
   logic sleep_state3_n_o, sleep_state4_n_o, sleep_state5_n_o, deep_sleep_req_o;
   logic button_level_status_o, button_event_status_o, power_fail_trip_flag_o;
   logic internal_pm_event_status_o, pm_event_pulse_o, host_reset_o, power_cycle_reset_o;
   logic resume_block_o, flash_allow_o;
   int   err_total = 0;
   int   cmp_count = 0;
   int   cyc = 0;

   power_event_inputs #(.DEBOUNCE_CYCLES(4)) i_dut (.*);

   ec_model #(.RST_CYC(4), .WIN_CYC(30)) i_ec (
      .clk_sys_i          (clk_sys_i),
      .sleep_a_n_i        (sleep_a_n_i),
      .platform_reset_n_i (platform_reset_n_i),
      .resetn_o           (resetn_i),
      .resume_holdoff_n_o (resume_holdoff_n_i)
   );

   // ************************************************************
   // Clock, timeout and shared helpers
   // ************************************************************
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   // Cut a hang short
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 70000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("mismatches=%0d compares=%0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #10;
   endtask

   task automatic sleep_outs(input logic exp);
      chk({sleep_state3_n_o, sleep_state4_n_o, sleep_state5_n_o}, {3{exp}});
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   // Level status raw versus debounced
   task automatic t_level;
      button_debounce_select_i = 1'b1;
      power_button_n_i = 1'b0;
      tick(3);
      chk(button_level_status_o, 1);
      power_button_n_i = 1'b1;
      tick(12);
      button_debounce_select_i = 1'b0;
      power_button_n_i = 1'b0;
      tick(3);
      chk(button_level_status_o, 0);
      tick(9);
      chk(button_level_status_o, 1);
      power_button_n_i = 1'b1;
      tick(12);
   endtask

   // Short holds restart the count; a full hold forces off without power good
   task automatic t_override;
      power_good_in_i = 1'b0;
      repeat (2) begin
         power_button_n_i = 1'b0;
         tick(16);
         power_button_n_i = 1'b1;
         tick(10);
         sleep_outs(1'b1);
      end
      power_button_n_i = 1'b0;
      tick(40);
      sleep_outs(1'b0);
      chk(deep_sleep_req_o, 1);
      power_button_n_i = 1'b1;
      power_good_in_i = 1'b1;
      processor_power_good_i = 1'b0;
      tick(12);
      processor_power_good_i = 1'b1;
      tick(6);
      sleep_outs(1'b1);
   endtask

   // PCIe event edges and internal event status
   task automatic t_pme;
      pcie_pm_event_n_i = 1'b0;
      tick(2);
      chk(pm_event_pulse_o, 1);
      tick(1);
      chk(pm_event_pulse_o, 0);
      pcie_pm_event_n_i = 1'b1;
      repeat (5) begin
         tick(1);
         chk(pm_event_pulse_o, 0);
      end
      internal_pm_req_i = 1'b1;
      tick(1);
      internal_pm_req_i = 1'b0;
      tick(1);
      chk(internal_pm_event_status_o, 1);
      status_clear_i = 1'b1;
      tick(1);
      status_clear_i = 1'b0;
      tick(1);
      chk(internal_pm_event_status_o, 0);
   endtask

   // Trip outside the window, a glitch, a real trip, trip after power loss
   task automatic t_trip;
      chk(button_event_status_o, 1);
      thermal_trip_n_i = 1'b0;
      tick(6);
      chk(power_fail_trip_flag_o, 0);
      thermal_trip_n_i = 1'b1;
      platform_reset_n_i = 1'b1;
      tick(4);
      thermal_trip_n_i = 1'b0;
      #20 thermal_trip_n_i = 1'b1;
      tick(5);
      sleep_outs(1'b1);
      thermal_trip_n_i = 1'b0;
      tick(3);
      sleep_outs(1'b0);
      chk(power_fail_trip_flag_o, 1);
      chk(button_event_status_o, 0);
      thermal_trip_n_i = 1'b1;
      processor_power_good_i = 1'b0;
      tick(3);
      status_clear_i = 1'b1;
      tick(1);
      status_clear_i = 1'b0;
      tick(2);
      thermal_trip_n_i = 1'b0;
      tick(6);
      chk(power_fail_trip_flag_o, 0);
      thermal_trip_n_i = 1'b1;
      processor_power_good_i = 1'b1;
      tick(6);
      sleep_outs(1'b1);
   endtask

   // Holdoff: pin as plain input, selected, and masked by eSPI
   task automatic t_holdoff;
      sleep_entry_i = 1'b1;
      for (int k = 0; k < 3; k++) begin
         holdoff_func_sel_i = (k != 0);
         espi_en_i = (k == 2);
         sleep_a_n_i = 1'b0;
         tick(5);
         chk(resume_block_o, k == 1);
         chk(flash_allow_o, 0);
         sleep_a_n_i = 1'b1;
         tick(5);
         chk(flash_allow_o, k != 1);
         tick(30);
         chk(flash_allow_o, 1);
      end
      sleep_entry_i = 1'b0;
      espi_en_i = 1'b0;
      sleep_a_n_i = 1'b0;
      tick(5);
      chk(resume_block_o, 0);
      sleep_a_n_i = 1'b1;
      tick(35);
   endtask

   // Reset button: power good gating, pulse length, re-arm, power cycle
   task automatic t_reset_btn;
      int n;
      n = 0;
      power_good_in_i = 1'b0;
      reset_button_n_i = 1'b0;
      tick(8);
      chk(host_reset_o, 0);
      reset_button_n_i = 1'b1;
      power_good_in_i = 1'b1;
      tick(6);
      reset_button_n_i = 1'b0;
      tick(3);
      chk(host_reset_o, 1);
      chk(power_cycle_reset_o, 0);
      while (host_reset_o === 1'b1 && n < 65000) begin
         tick(1);
         n++;
      end
      chk(n >= 50000 && n <= 60000, 1);
      tick(10);
      chk(host_reset_o, 0);
      reset_button_n_i = 1'b1;
      reset_control_i = 8'h08;
      reset_debounce_en_i = 1'b1;
      tick(10);
      reset_button_n_i = 1'b0;
      tick(3);
      chk(power_cycle_reset_o, 0);
      tick(10);
      chk(power_cycle_reset_o, 1);
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {power_button_n_i, reset_button_n_i, thermal_trip_n_i, pcie_pm_event_n_i} = 4'hf;
      {power_good_in_i, processor_power_good_i, sleep_a_n_i, deep_sleep_en_i} = 4'hf;
      {platform_reset_n_i, internal_pm_req_i, sleep_entry_i, button_debounce_select_i} = 4'h0;
      {reset_debounce_en_i, trip_valid_point_i, holdoff_func_sel_i, espi_en_i} = 4'h0;
      status_clear_i = 1'b0;
      override_period_i = 32'h00000014;
      reset_control_i = 8'h00;
      @(posedge resetn_i);
      tick(2);
      sleep_outs(1'b1);
      chk(OVERRIDE_DEFAULT, 32'h02625a00);
      t_pme();
      t_level();
      t_override();
      t_trip();
      t_holdoff();
      t_reset_btn();
      give_verdict();
   end

endmodule

`default_nettype wire
